// >>> common/zone_consts.vh
`ifndef ZONE_CONSTS_VH
`define ZONE_CONSTS_VH
// register offsets (byte addresses, one word each)
`define REG_CTRL 8'h00
`define REG_TH1 8'h04
`define REG_TH2 8'h08
`define REG_TH3 8'h0C
`define REG_TH4 8'h10
`define REG_HYST 8'h14
`define REG_DELAY 8'h18
`define REG_FSW 8'h1C
`define REG_STATUS 8'h20
// ctrl fields: [2:0] fixed_zone_normal, [6:4] fixed_zone_boot, [8] boot_done
`define CTRL_NORM_LSB 0
`define CTRL_BOOT_LSB 4
`define CTRL_BOOT_DONE 8
// reset values
`define TH_DISABLED 8'hFF
`define HYST_RESET 8'h10
`define DELAY_RESET 8'h14
`define FSW_RESET 8'h00
`define CTRL_RESET 9'h000
// timing
`define SAMPLE_US 10
`define STEP_US 10
`define CLK_MHZ 100
`define DCM_FSW_KHZ 100
// power-save states
`define PS_LOW 2'b00
`define PS_MID 2'b01
`define PS_HIGH 2'b10
`endif

// >>> hdl/power_zone_phase_shedding.v
// Operation
// - power-save high forces zone zero, all phases
// - mid state samples current every 10 us
// - all-ones threshold code means disabled
// - low state: boot setting, then normal setting
// - low uses fixed setting, mid uses thresholds
// - above th3 zone0; th3-th2 zone2 four-phase
// - th2-th1 zone3 except single; below th1 zone4
// - phase enables follow zone and configuration
// - moves to lower zone happen immediately
// - moves to higher zone wait shed delay
// - step through intermediate zones, delay each
// - hysteresis applies before moving to higher zone
// - hysteresis defaults 0x10, software writable
// - skip disabled zones during transitions
// - fixed-zone changes use same stepped transition
// - fixed target zone is force-enabled
// - back in auto mode, forced zones disabled
// - switching frequency setting readable and writable
//
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/10ps
`include "zone_consts.vh"
module power_zone_phase_shedding #(
  parameter ADDR_W = 8
) (
  // clock and reset
  input wire ref_clk,
  input wire sys_rst,
  // pins and sensed values
  input wire [1:0] power_save_select,
  input wire [7:0] total_current_level,
  input wire [1:0] phase_count_code,
  // register port
  input wire [ADDR_W-1:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // drive outputs
  output reg phase_drive_1,
  output reg phase_drive_2,
  output reg phase_drive_3,
  output reg phase_drive_4,
  output reg dcm_mode,
  output reg [7:0] switching_frequency_setting
);
  // the products are 32-bit; the counters only need 12 bits
  localparam [31:0] SAMPLE_FULL = `SAMPLE_US * `CLK_MHZ;
  localparam [31:0] STEP_FULL = `STEP_US * `CLK_MHZ;
  localparam [11:0] SAMPLE_CYC = SAMPLE_FULL[11:0];
  localparam [11:0] STEP_CYC = STEP_FULL[11:0];

  // ==========================================
  // registers
  reg [8:0] ctrl_reg;
  reg [7:0] th_reg [0:3];
  reg [7:0] hyst_reg;
  reg [7:0] delay_reg;
  reg [1:0] ps_meta_reg;
  reg [1:0] ps_reg;
  reg [7:0] cur_reg;
  reg [2:0] zone_reg;
  reg [2:0] zone_next;
  reg [11:0] sample_cnt_reg;
  reg [11:0] step_cnt_reg;
  reg [7:0] delay_cnt_reg;
  reg [2:0] target;
  reg [2:0] up_target;
  reg [1:0] cfg_meta_reg;
  reg [1:0] cfg_reg;
  reg [7:0] cur_meta_reg;
  reg [7:0] cur_sync_reg;
  wire [2:0] fixed_norm = ctrl_reg[`CTRL_NORM_LSB+2:`CTRL_NORM_LSB];
  wire [2:0] fixed_boot = ctrl_reg[`CTRL_BOOT_LSB+2:`CTRL_BOOT_LSB];
  // phase_count_code: 0=4, 1=3, 2=2, 3=1 phases
  wire four_ph = (cfg_reg == 2'd0);
  wire single_ph = (cfg_reg == 2'd3);

  // zone usable in auto mode given configuration and threshold
  function zone_ok;
    input [2:0] z;
    input four;
    input single;
    input [7:0] t2;
    input [7:0] t3;
    input [7:0] t1;
    begin
      case (z)
        3'd0: zone_ok = 1'b1;
        3'd2: zone_ok = four && (t3 != `TH_DISABLED);
        3'd3: zone_ok = !single && (t2 != `TH_DISABLED);
        3'd4: zone_ok = (t1 != `TH_DISABLED);
        default: zone_ok = 1'b0;
      endcase
    end
  endfunction

  // ==========================================
  // zone selection from current
  integer i;
  reg [7:0] lo [0:3];
  reg [2:0] down_target;
  reg [2:0] want;
  always @* begin
    for (i = 0; i < 4; i = i + 1) begin
      lo[i] = (th_reg[i] > hyst_reg) ? (th_reg[i] - hyst_reg) : 8'h00;
    end
    // a disabled threshold is skipped, so only enabled zones are chosen
    if (th_reg[0] != `TH_DISABLED && cur_reg <= th_reg[0])
      down_target = 3'd4;
    else if (th_reg[1] != `TH_DISABLED && cur_reg <= th_reg[1])
      down_target = single_ph ? 3'd0 : 3'd3;
    else if (th_reg[2] != `TH_DISABLED && cur_reg <= th_reg[2])
      down_target = four_ph ? 3'd2 : 3'd0;
    else
      down_target = 3'd0;
    if (th_reg[0] != `TH_DISABLED && cur_reg < lo[0])
      up_target = 3'd4;
    else if (th_reg[1] != `TH_DISABLED && cur_reg < lo[1])
      up_target = single_ph ? 3'd0 : 3'd3;
    else if (th_reg[2] != `TH_DISABLED && cur_reg < lo[2])
      up_target = four_ph ? 3'd2 : 3'd0;
    else
      up_target = 3'd0;
    if (down_target < zone_reg)
      want = down_target;
    else if (up_target > zone_reg)
      want = up_target;
    else
      want = zone_reg;
    case (ps_reg)
      `PS_HIGH: target = 3'd0;
      `PS_MID: begin
        // a zone that was only force-enabled is left again
        if (want == zone_reg && !zone_ok(zone_reg, four_ph, single_ph, th_reg[1], th_reg[2], th_reg[0]))
          target = up_target;
        else
          target = want;
      end
      `PS_LOW: target = ctrl_reg[`CTRL_BOOT_DONE] ? fixed_norm : fixed_boot;
      default: target = 3'd0;
    endcase
    if (target == 3'd1 || target > 3'd4)
      target = 3'd0;
  end

  // next zone one step toward target, skipping disabled zones
  reg [2:0] cand;
  reg found;
  integer k;
  always @* begin
    zone_next = zone_reg;
    found = 1'b0;
    cand = 3'd0;
    if (target > zone_reg) begin
      for (k = 1; k <= 4; k = k + 1) begin
        cand = zone_reg + k[2:0];
        if (!found && cand <= target &&
            (cand == target || zone_ok(cand, four_ph, single_ph, th_reg[1], th_reg[2], th_reg[0]))) begin
          zone_next = cand;
          found = 1'b1;
        end
      end
    end else if (target < zone_reg) begin
      for (k = 1; k <= 4; k = k + 1) begin
        cand = zone_reg - k[2:0];
        if (!found && cand >= target &&
            (cand == target || zone_ok(cand, four_ph, single_ph, th_reg[1], th_reg[2], th_reg[0]))) begin
          zone_next = cand;
          found = 1'b1;
        end
      end
    end
  end

  // ==========================================
  // sequencing
  // configuration and current synchronisers have no reset: reset must be held two edges so the configuration settles
  always @(posedge ref_clk) begin
    cfg_meta_reg <= phase_count_code;
    cfg_reg <= cfg_meta_reg;
    cur_meta_reg <= total_current_level;
    cur_sync_reg <= cur_meta_reg;
  end

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      ps_meta_reg <= `PS_HIGH;
      ps_reg <= `PS_HIGH;
      cur_reg <= 8'h00;
      zone_reg <= 3'd0;
      sample_cnt_reg <= 12'h000;
      step_cnt_reg <= 12'h000;
      delay_cnt_reg <= 8'h00;
    end else begin
      ps_meta_reg <= power_save_select;
      ps_reg <= ps_meta_reg;
      if (sample_cnt_reg == SAMPLE_CYC - 12'd1) begin
        sample_cnt_reg <= 12'h000;
        cur_reg <= cur_sync_reg;
      end else begin
        sample_cnt_reg <= sample_cnt_reg + 12'd1;
      end
      if (zone_next < zone_reg) begin
        zone_reg <= zone_next;
        step_cnt_reg <= 12'h000;
        delay_cnt_reg <= 8'h00;
      end else if (zone_next > zone_reg) begin
        if (step_cnt_reg == STEP_CYC - 12'd1) begin
          step_cnt_reg <= 12'h000;
          if (delay_cnt_reg + 8'd1 >= delay_reg) begin
            delay_cnt_reg <= 8'h00;
            zone_reg <= zone_next;
          end else begin
            delay_cnt_reg <= delay_cnt_reg + 8'd1;
          end
        end else begin
          step_cnt_reg <= step_cnt_reg + 12'd1;
        end
      end else begin
        step_cnt_reg <= 12'h000;
        delay_cnt_reg <= 8'h00;
      end
    end
  end

  // ==========================================
  // outputs
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      phase_drive_1 <= 1'b0;
      phase_drive_2 <= 1'b0;
      phase_drive_3 <= 1'b0;
      phase_drive_4 <= 1'b0;
      dcm_mode <= 1'b0;
    end else begin
      phase_drive_1 <= 1'b1;
      phase_drive_2 <= (zone_reg == 3'd0) && !single_ph;
      phase_drive_3 <= ((zone_reg == 3'd0) && (cfg_reg <= 2'd1)) || ((zone_reg == 3'd2) && four_ph);
      phase_drive_4 <= (zone_reg == 3'd0) && four_ph;
      dcm_mode <= (zone_reg == 3'd4);
    end
  end

  // ==========================================
  // register port
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl_reg <= `CTRL_RESET;
      th_reg[0] <= `TH_DISABLED;
      th_reg[1] <= `TH_DISABLED;
      th_reg[2] <= `TH_DISABLED;
      th_reg[3] <= `TH_DISABLED;
      hyst_reg <= `HYST_RESET;
      delay_reg <= `DELAY_RESET;
      switching_frequency_setting <= `FSW_RESET;
      reg_rdata <= 32'h00000000;
    end else begin
      reg_rdata <= 32'h00000000;
      if (reg_wr) begin
        case (reg_addr)
          `REG_CTRL: ctrl_reg <= reg_wdata[8:0];
          `REG_TH1: th_reg[0] <= reg_wdata[7:0];
          `REG_TH2: th_reg[1] <= reg_wdata[7:0];
          `REG_TH3: th_reg[2] <= reg_wdata[7:0];
          `REG_TH4: th_reg[3] <= reg_wdata[7:0];
          `REG_HYST: hyst_reg <= reg_wdata[7:0];
          `REG_DELAY: delay_reg <= (reg_wdata[7:0] == 8'h00) ? 8'h01 : reg_wdata[7:0];
          `REG_FSW: switching_frequency_setting <= reg_wdata[7:0];
          default: ;
        endcase
      end
      if (reg_rd) begin
        case (reg_addr)
          `REG_CTRL: reg_rdata <= {23'h000000, ctrl_reg};
          `REG_TH1: reg_rdata <= {24'h000000, th_reg[0]};
          `REG_TH2: reg_rdata <= {24'h000000, th_reg[1]};
          `REG_TH3: reg_rdata <= {24'h000000, th_reg[2]};
          `REG_TH4: reg_rdata <= {24'h000000, th_reg[3]};
          `REG_HYST: reg_rdata <= {24'h000000, hyst_reg};
          `REG_DELAY: reg_rdata <= {24'h000000, delay_reg};
          `REG_FSW: reg_rdata <= {24'h000000, switching_frequency_setting};
          `REG_STATUS: reg_rdata <= {20'h00000, cur_reg, dcm_mode, zone_reg};
          default: reg_rdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule

// >>> test/zone_chk.sv
`timescale 1ns/10ps
`include "zone_consts.vh"
module zone_chk #(
  parameter ADDR_W = 8
) (
  // clock and reset
  input wire ref_clk,
  input wire sys_rst,
  // pins
  input wire [1:0] power_save_select,
  input wire [7:0] total_current_level,
  input wire [1:0] phase_count_code,
  // register port
  input wire [ADDR_W-1:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  // drive outputs
  input wire phase_drive_1,
  input wire phase_drive_2,
  input wire phase_drive_3,
  input wire phase_drive_4,
  input wire dcm_mode,
  input wire [7:0] switching_frequency_setting
);
  // ====
  // shed spacing helper
  logic [3:0] prv_reg;
  logic [10:0] gap_reg;
  wire shed = |(prv_reg[2:0] & ~{phase_drive_4, phase_drive_3, phase_drive_2}) || (dcm_mode && !prv_reg[3]);
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      prv_reg <= 4'h0;
      gap_reg <= 11'h000;
    end else begin
      prv_reg <= {dcm_mode, phase_drive_4, phase_drive_3, phase_drive_2};
      if (shed)
        gap_reg <= 11'h000;
      else if (gap_reg != 11'h7FF)
        gap_reg <= gap_reg + 11'h001;
    end
  end
  // ====
  // properties
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_drive_one_on: assert property (!$past(sys_rst) |-> phase_drive_1)
    else $error("phase 1 off");
  a_dcm_single: assert property (dcm_mode |-> !(phase_drive_2 || phase_drive_3 || phase_drive_4))
    else $error("extra phase in dcm");
  a_four_only: assert property (phase_count_code != 2'h0 |-> !phase_drive_4)
    else $error("phase 4 not configured");
  a_zone0_full: assert property (phase_drive_4 |-> phase_drive_2 && phase_drive_3)
    else $error("partial zone 0");
  a_high_full: assert property (power_save_select[1] [*6] |-> phase_drive_2 || phase_count_code == 2'h3)
    else $error("high mode shed");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside slot");
  a_fsw_write: assert property (reg_wr && reg_addr == `REG_FSW |=>
    switching_frequency_setting == $past(reg_wdata[7:0]))
    else $error("frequency write lost");
  a_fsw_read: assert property (reg_rd && reg_addr == `REG_FSW |=> reg_rdata == {24'h0, switching_frequency_setting})
    else $error("frequency read wrong");
  a_shed_gap: assert property (shed |-> gap_reg > 11'd900)
    else $error("shed step too soon");
  c_dcm_entry: cover property ($rose(dcm_mode));
  c_zone_two: cover property (phase_drive_3 && !phase_drive_2);
  c_fsw_wr: cover property (reg_wr && reg_addr == `REG_FSW);
endmodule
bind power_zone_phase_shedding zone_chk #(.ADDR_W(ADDR_W)) chk_i (
  .ref_clk(ref_clk), .sys_rst(sys_rst),
  .power_save_select(power_save_select), .total_current_level(total_current_level),
  .phase_count_code(phase_count_code),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .phase_drive_1(phase_drive_1), .phase_drive_2(phase_drive_2),
  .phase_drive_3(phase_drive_3), .phase_drive_4(phase_drive_4),
  .dcm_mode(dcm_mode), .switching_frequency_setting(switching_frequency_setting)
);

// >>> test/testbench.sv
`timescale 1ns/10ps
`include "zone_consts.vh"
module testbench;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [1:0] power_save_select = `PS_HIGH;
  logic [7:0] total_current_level = 8'h80;
  logic [1:0] phase_count_code = 2'h0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  wire [31:0] reg_rdata;
  wire phase_drive_1, phase_drive_2, phase_drive_3, phase_drive_4, dcm_mode;
  wire [7:0] switching_frequency_setting;
  wire [4:0] drv = {dcm_mode, phase_drive_4, phase_drive_3, phase_drive_2, phase_drive_1};
  int n_fail = 0;
  int compares = 0;
  logic [7:0] exp_reg [0:7] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h10, 8'h14, 8'h00, 8'h00};

  always #5 ref_clk = ~ref_clk;

  power_zone_phase_shedding dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst),
    .power_save_select(power_save_select), .total_current_level(total_current_level),
    .phase_count_code(phase_count_code),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .phase_drive_1(phase_drive_1), .phase_drive_2(phase_drive_2),
    .phase_drive_3(phase_drive_3), .phase_drive_4(phase_drive_4),
    .dcm_mode(dcm_mode), .switching_frequency_setting(switching_frequency_setting)
  );

  // ====
  // tasks
  task chk(input [31:0] g, input [31:0] e);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task wr(input [7:0] a, input [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task rd(input [7:0] a, input [31:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask

  task drive(input [7:0] c, input [1:0] s);
    @(posedge ref_clk);
    total_current_level <= c;
    power_save_select <= s;
    #1;
  endtask

  // the first change of the drives must be the expected zone, inside the cycle window
  task step(input [4:0] e, input int lo, input int hi);
    int n;
    logic [4:0] p;
    n = 0;
    p = drv;
    while (drv === p && n < 2100) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk(drv, e);
    chk(n >= lo && n <= hi, 1);
  endtask

  task print_verdict;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ====
  // sequence
  initial begin
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 8; i++) rd(i == 7 ? 8'h24 : 8'(4 * i + 4), {24'h0, exp_reg[i]});
    wr(`REG_HYST, 32'h08);
    rd(`REG_HYST, 32'h08);
    wr(`REG_FSW, 32'h5A);
    rd(`REG_FSW, 32'h5A);
    chk(switching_frequency_setting, 8'h5A);
    chk(drv, 5'h0F);
    wr(`REG_DELAY, 32'h1);
    wr(`REG_TH1, 32'h20);
    wr(`REG_TH2, 32'h40);
    wr(`REG_TH3, 32'h60);
    // inside the hysteresis band nothing may shed
    drive(8'h5C, `PS_MID);
    repeat (2500) @(posedge ref_clk);
    #1 chk(drv, 5'h0F);
    drive(8'h57, `PS_MID);
    step(5'h05, 990, 2010);
    drive(8'h05, `PS_MID);
    step(5'h01, 990, 2010);
    step(5'h11, 990, 1010);
    drive(8'h80, `PS_MID);
    step(5'h01, 1, 1010);
    step(5'h05, 1, 2);
    step(5'h0F, 1, 2);
    wr(`REG_TH2, 32'hFF);
    drive(8'h05, `PS_MID);
    step(5'h05, 990, 2010);
    step(5'h11, 990, 1010);
    wr(`REG_CTRL, 32'h32);
    drive(8'h05, `PS_LOW);
    step(5'h01, 1, 20);
    wr(`REG_CTRL, 32'h132);
    step(5'h05, 1, 20);
    wr(`REG_CTRL, 32'h134);
    step(5'h11, 950, 1010);
    drive(8'h30, `PS_MID);
    step(5'h05, 1, 1010);
    drive(8'h05, `PS_HIGH);
    step(5'h0F, 1, 20);
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    phase_count_code <= 2'h3;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 chk(drv, 5'h01);
    print_verdict;
  end

  // the full sequence needs about 13000 cycles
  initial begin
    #400000;
    n_fail++;
    print_verdict;
  end
endmodule
